// ==== spsm_regs.svh ====
// Purpose: Constants of the serial port signal-mode block.
// Assumes: Included by the package and the port module.
// Notes: Definitions only.
`ifndef SPSM_REGS_SVH
`define SPSM_REGS_SVH

`define SPSM_MODE_3WIRE 2'h0
`define SPSM_MODE_4W_IN 2'h1
`define SPSM_BIT_LAST 3'h7
`define SPSM_CTL_RST 12'h004
`define SPSM_DIV_RST 8'h03

`endif

// ==== spsm_pkg.sv ====
// Purpose: Types of the serial port signal-mode block.
// Assumes: spsm_regs.svh holds the numbers.
// Notes: Software-facing groups travel as packed structs.
`default_nettype none
package spsm_pkg;
	`include "spsm_regs.svh"

	typedef struct packed {
		logic [7:0] clk_div;
		logic [1:0] select_mode_field;
		logic master_role_enable;
		logic port_enable_bit;
	} spsm_ctl_t;

	typedef struct packed {
		logic transfer_done_flag;
		logic write_collision;
		logic mode_fault_flag;
		logic rx_overrun;
	} spsm_flags_t;

	typedef enum logic [1:0] {
		SPSM_IDLE = 2'h0,
		SPSM_RUN = 2'h1,
		SPSM_TAIL = 2'h3
	} spsm_fsm_t;

	typedef struct packed {
		spsm_ctl_t ctl;
		spsm_flags_t flags;
		logic sck_s1, sck_s2, sck_s3;
		logic mosi_s1, mosi_s2;
		logic miso_s1, miso_s2;
		logic sel_s1, sel_s2, sel_s3;
		logic [7:0] sr;
		logic sr_full;
		logic [7:0] txbuf;
		logic tx_full;
		logic [7:0] rxbuf;
		logic rx_full;
		logic samp;
		logic [2:0] bit_cnt;
		spsm_fsm_t fsm;
		logic [7:0] div_cnt;
		logic sck_o;
	} spsm_state_t;
endpackage
`default_nettype wire

// ==== spsm_port.sv ====
// Purpose: Full-duplex serial port, master or slave, with three select wiring modes.
// Assumes: Clock polarity low, data sampled on the rising SCK edge.
// Notes: Pins arrive asynchronous and pass two flops before use.
//
// What this block does
// - Drive MOSI as master, take it as input as slave.
// - Shift both data lines most significant bit first.
// - As master, MOSI shows the shift register MSB in both wirings.
// - Sample MISO as master, drive MISO as slave.
// - Release MISO when disabled or an unselected 4-wire slave.
// - As 3-wire slave, drive MISO continuously from shift register MSB.
// - Generate SCK only as master; as slave SCK is an input.
// - In 4-wire slave mode ignore SCK edges while select is high.
// - Mode 00 is 3-wire; a slave then always counts as selected.
// - Mode 01 is 4-wire with the select pin as input.
// - In 4-wire slave mode respond only while the master selects us.
// - Mode 01 master: select going low disables the master function.
// - Mode 1x drives the select pin at the lower mode bit level.
// - Select pin unrouted in mode 00 (3-wire), routed in all others.
// - Multi-master select low clears master and port enables, sets fault flag.
// - After eight bits set done flag and copy the byte to receive buffer; a slave with an unread full buffer sets overrun instead.
// - 4-wire slave: select falling resets bit counter; master select is a static level from the mode bits, not timed to SCK.
// - Master: data write moves to empty shift register and starts transfer.
`default_nettype none
`include "spsm_regs.svh"
module spsm_port (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ctl_wr,
	input wire spsm_pkg::spsm_ctl_t ctl_wdata,
	output spsm_pkg::spsm_ctl_t ctl_rdata,
	input wire logic dat_wr,
	input wire logic [7:0] dat_wdata,
	input wire logic rx_rd,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire spsm_pkg::spsm_flags_t flag_clr,
	output spsm_pkg::spsm_flags_t flags,
	output logic busy,
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	input wire logic sel_n_in,
	output logic sel_n_out,
	output logic sel_n_oe,
	output logic sel_routed
);
	import spsm_pkg::*;

	spsm_state_t st_ff;
	spsm_state_t nxt_st;
	logic en, mst, four_in, slv_sel, sel_fall;
	logic s_rise, s_fall, tick, m_rise, m_fall, rise, fall, din, last;

	////////////////////////////////////////////////////////////////////////
	// Decode of role, mode and edges
	always_comb begin
		en = st_ff.ctl.port_enable_bit;
		mst = st_ff.ctl.master_role_enable;
		four_in = (st_ff.ctl.select_mode_field == `SPSM_MODE_4W_IN);
		// Only mode 01 has a select input; other modes stay selected
		slv_sel = four_in ? ~st_ff.sel_s2 : 1'b1;
		sel_fall = st_ff.sel_s3 & ~st_ff.sel_s2;
		s_rise = st_ff.sck_s2 & ~st_ff.sck_s3;
		s_fall = ~st_ff.sck_s2 & st_ff.sck_s3;
		tick = (st_ff.fsm != SPSM_IDLE) && (st_ff.div_cnt == 8'h00);
		m_rise = tick && (st_ff.fsm == SPSM_RUN) && !st_ff.sck_o;
		m_fall = tick && (st_ff.fsm == SPSM_RUN) && st_ff.sck_o;
		// Slave ignores SCK while deselected; master uses its own edges
		rise = en && (mst ? m_rise : (s_rise && slv_sel));
		fall = en && (mst ? m_fall : (s_fall && slv_sel));
		din = mst ? st_ff.miso_s2 : st_ff.mosi_s2;
		last = (st_ff.bit_cnt == `SPSM_BIT_LAST);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sck_s1 = sck_in;
		nxt_st.sck_s2 = st_ff.sck_s1;
		nxt_st.sck_s3 = st_ff.sck_s2;
		nxt_st.mosi_s1 = mosi_in;
		nxt_st.mosi_s2 = st_ff.mosi_s1;
		nxt_st.miso_s1 = miso_in;
		nxt_st.miso_s2 = st_ff.miso_s1;
		nxt_st.sel_s1 = sel_n_in;
		nxt_st.sel_s2 = st_ff.sel_s1;
		nxt_st.sel_s3 = st_ff.sel_s2;

		if (ctl_wr) begin
			nxt_st.ctl = ctl_wdata;
		end
		// Clears first, so a flag set in the same cycle survives
		nxt_st.flags = st_ff.flags & ~flag_clr;
		if (rx_rd) begin
			nxt_st.rx_full = 1'b0;
		end

		// Double buffer: a write while the buffer is full is dropped
		if (dat_wr) begin
			if (st_ff.tx_full) begin
				nxt_st.flags.write_collision = 1'b1;
			end else begin
				nxt_st.txbuf = dat_wdata;
				nxt_st.tx_full = 1'b1;
			end
		end
		if (st_ff.tx_full && !st_ff.sr_full) begin
			nxt_st.sr = st_ff.txbuf;
			nxt_st.sr_full = 1'b1;
			nxt_st.tx_full = 1'b0;
		end

		// Sample on rising, shift on falling, MSB leaves first
		if (rise) begin
			if (last) begin
				nxt_st.flags.transfer_done_flag = 1'b1;
				nxt_st.bit_cnt = 3'h0;
				nxt_st.sr_full = 1'b0;
				if (st_ff.rx_full && !rx_rd && !mst) begin
					nxt_st.flags.rx_overrun = 1'b1;
				end else begin
					nxt_st.rxbuf = {st_ff.sr[6:0], din};
					nxt_st.rx_full = 1'b1;
				end
			end else begin
				nxt_st.samp = din;
				nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
			end
		end
		if (fall && st_ff.bit_cnt != 3'h0) begin
			nxt_st.sr = {st_ff.sr[6:0], st_ff.samp};
		end
		// A 3-wire slave realigns only by toggling the port enable
		if (!en || (!mst && four_in && sel_fall)) begin
			nxt_st.bit_cnt = 3'h0;
		end

		// Master clock generator
		if (tick) begin
			nxt_st.div_cnt = st_ff.ctl.clk_div;
		end else if (st_ff.fsm != SPSM_IDLE) begin
			nxt_st.div_cnt = st_ff.div_cnt - 8'h01;
		end
		case (st_ff.fsm)
			SPSM_IDLE: begin
				if (en && mst && st_ff.sr_full) begin
					nxt_st.fsm = SPSM_RUN;
					nxt_st.div_cnt = st_ff.ctl.clk_div;
				end
			end
			SPSM_RUN: begin
				if (tick) begin
					nxt_st.sck_o = ~st_ff.sck_o;
				end
				if (m_rise && last) begin
					nxt_st.fsm = SPSM_TAIL;
				end
			end
			SPSM_TAIL: begin
				if (tick) begin
					nxt_st.sck_o = 1'b0;
					nxt_st.fsm = SPSM_IDLE;
				end
			end
			default: begin
				nxt_st.fsm = SPSM_IDLE;
			end
		endcase
		if (!en || !mst) begin
			nxt_st.fsm = SPSM_IDLE;
			nxt_st.sck_o = 1'b0;
		end

		// Another master took the bus: fault beats any software write
		if (en && mst && four_in && !st_ff.sel_s2) begin
			nxt_st.ctl.master_role_enable = 1'b0;
			nxt_st.ctl.port_enable_bit = 1'b0;
			nxt_st.flags.mode_fault_flag = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.ctl <= `SPSM_CTL_RST;
			st_ff.ctl.clk_div <= `SPSM_DIV_RST;
			st_ff.sck_s1 <= 1'b0;
			st_ff.sel_s1 <= 1'b1;
			st_ff.sel_s2 <= 1'b1;
			st_ff.sel_s3 <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and status
	always_comb begin
		ctl_rdata = st_ff.ctl;
		flags = st_ff.flags;
		rx_data = st_ff.rxbuf;
		rx_valid = st_ff.rx_full;
		busy = st_ff.sr_full;
		sck_out = st_ff.sck_o;
		sck_oe = en && mst;
		mosi_out = st_ff.sr[7];
		mosi_oe = en && mst;
		miso_out = st_ff.sr[7];
		miso_oe = en && !mst && slv_sel;
		sel_n_out = st_ff.ctl.select_mode_field[0];
		sel_n_oe = st_ff.ctl.select_mode_field[1];
		sel_routed = (st_ff.ctl.select_mode_field != `SPSM_MODE_3WIRE);
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	miso_release_a: assert property ((!en || (!mst && four_in && st_ff.sel_s2)) |-> !miso_oe)
		else $error("MISO driven while released");
	slave_3w_a: assert property ((en && !mst && !st_ff.ctl.select_mode_field[1]
		&& !four_in) |-> (miso_oe && miso_out == st_ff.sr[7]))
		else $error("3-wire slave not driving MISO");
	sck_ignore_a: assert property ((en && !mst && four_in && st_ff.sel_s2)
		|=> $stable(st_ff.bit_cnt) && $stable(st_ff.rxbuf))
		else $error("Deselected slave reacted to SCK");
	mode_fault_a: assert property ((en && mst && four_in && !st_ff.sel_s2)
		|=> (!st_ff.ctl.port_enable_bit && !st_ff.ctl.master_role_enable
		&& st_ff.flags.mode_fault_flag))
		else $error("Mode fault did not disable master");
	sel_drive_a: assert property (st_ff.ctl.select_mode_field[1]
		|-> (sel_n_oe && sel_n_out == st_ff.ctl.select_mode_field[0]))
		else $error("Select output level wrong");
	sel_route_a: assert property ((st_ff.ctl.select_mode_field == 2'h0) == !sel_routed)
		else $error("Select routing wrong");
	byte_done_a: assert property ((rise && last) |=> (st_ff.flags.transfer_done_flag
		&& st_ff.bit_cnt == 3'h0))
		else $error("Byte end not flagged");
	cnt_reset_a: assert property ((en && !mst && four_in && sel_fall) |=> st_ff.bit_cnt == 3'h0)
		else $error("Bit counter not reset on select");
	master_start_a: assert property ((en && mst && st_ff.sr_full && st_ff.fsm == SPSM_IDLE
		&& !four_in) |=> st_ff.fsm == SPSM_RUN)
		else $error("Master transfer did not start");
	shift_msb_a: assert property ((fall && st_ff.bit_cnt != 3'h0)
		|=> st_ff.sr[0] == $past(st_ff.samp))
		else $error("Shift order wrong");
	sck_role_a: assert property ($rose(sck_out) |-> (sck_oe && st_ff.fsm != SPSM_IDLE))
		else $error("SCK pulse outside master run");

	master_byte_c: cover property ((st_ff.fsm == SPSM_TAIL) ##[1:300] st_ff.fsm == SPSM_IDLE);
	slave_byte_c: cover property (!mst && rise && last);
	fault_c: cover property (st_ff.flags.mode_fault_flag && !st_ff.ctl.port_enable_bit);
	overrun_c: cover property ($rose(st_ff.flags.rx_overrun));
endmodule
`default_nettype wire

// ==== spsm_peer.sv ====
// Purpose: Far-side serial device, master by task or slave by is_slave.
// Assumes: Mode 0 link, 160 ns clock period when mastering.
// Notes: Idle MOSI shows the inverse of the last bit sent, not a held value; slave MISO holds sr MSB.
`default_nettype none
module spsm_peer (
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic is_slave,
	output logic sck_o,
	output logic mosi_o,
	output logic miso_o,
	output logic sel_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sr = 8'h00;
	logic [7:0] rises = 8'h00;
	logic cap = 1'b0;
	initial begin
		sck_o = 1'b0;
		mosi_o = 1'b1;
		sel_n_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////
	// Slave side: take on rising, shift on falling, MSB first
	always @(posedge sck_i) if (is_slave) begin
		cap <= mosi_i;
		rises <= rises + 8'h01;
	end
	always @(negedge sck_i) if (is_slave) sr <= {sr[6:0], cap};
	assign miso_o = is_slave ? sr[7] : ~sr[7];
	task automatic load(input logic [7:0] b);
		sr = b;
		rises = 8'h00;
	endtask
	task automatic select(input logic s);
		sel_n_o = ~s;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Master side: clock stands low outside frames
	task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
		sel_n_o = ~sel;
		mosi_o = tx[7];
		#100;
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			#80 sck_o = 1'b1;
			rx[i] = miso_i;
			#80 sck_o = 1'b0;
		end
		#100 sel_n_o = 1'b1;
		mosi_o = ~tx[0];
	endtask
endmodule
`default_nettype wire

// ==== spi_port_signal_modes_test.sv ====
// Purpose: Self-checking bench of the signal-mode serial port.
// Assumes: Peer model on the far side; pins resolved from output enables.
// Notes: Control, data and flag ports are driven 2 ns after the clock edge.
`default_nettype none
module spi_port_signal_modes_test;
	timeunit 1ns;
	timeprecision 1ns;
	import spsm_pkg::*;
	logic mclk, rst_n, ctl_wr, dat_wr, rx_rd, busy, rx_valid, sel_routed, p_slave;
	spsm_ctl_t ctl_wdata, ctl_rdata;
	spsm_flags_t flag_clr, flags;
	logic [7:0] dat_wdata, rx_data, rx;
	logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, sel_n_out, sel_n_oe;
	logic p_sck, p_mosi, p_miso, p_sel, sck_w, mosi_w, miso_w, sel_w;
	int bad_count = 0;
	int compares = 0;
	assign sck_w = sck_oe ? sck_out : p_sck;
	assign mosi_w = mosi_oe ? mosi_out : p_mosi;
	assign miso_w = miso_oe ? miso_out : p_miso;
	assign sel_w = sel_n_oe ? sel_n_out : p_sel;
	spsm_port spsm_port_inst (.mclk(mclk), .rst_n(rst_n), .ctl_wr(ctl_wr),
		.ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .dat_wr(dat_wr),
		.dat_wdata(dat_wdata), .rx_rd(rx_rd), .rx_data(rx_data), .rx_valid(rx_valid),
		.flag_clr(flag_clr), .flags(flags), .busy(busy), .sck_in(sck_w),
		.sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
		.mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
		.sel_n_in(sel_w), .sel_n_out(sel_n_out), .sel_n_oe(sel_n_oe),
		.sel_routed(sel_routed));
	spsm_peer spsm_peer_inst (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
		.is_slave(p_slave), .sck_o(p_sck), .mosi_o(p_mosi), .miso_o(p_miso),
		.sel_n_o(p_sel));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	task automatic wr_ctl(input logic [7:0] dv, input logic [1:0] m, input logic ms, input logic en);
		ctl_wdata = {dv, m, ms, en};
		ctl_wr = 1'b1;
		tick(1);
		ctl_wr = 1'b0;
		tick(3);
	endtask
	task automatic wr_dat(input logic [7:0] d);
		dat_wdata = d;
		dat_wr = 1'b1;
		tick(1);
		dat_wr = 1'b0;
		tick(3);
	endtask
	task automatic clr_all();
		flag_clr = 4'hF;
		rx_rd = 1'b1;
		tick(1);
		flag_clr = 4'h0;
		rx_rd = 1'b0;
		tick(1);
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#300us;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		{rst_n, ctl_wr, dat_wr, rx_rd, p_slave} = 5'h00;
		{ctl_wdata, flag_clr, dat_wdata} = 24'h000000;
		tick(12);
		rst_n = 1'b1;
		tick(1);
		chk(ctl_rdata, {8'h03, 2'h1, 2'h0});
		chk({sel_routed, sel_n_oe, miso_oe}, 12'h004);
		// Unselected 4-wire slave stays off the bus and deaf to the clock
		wr_ctl(8'h01, 2'h1, 1'b0, 1'b1);
		wr_dat(8'hA5);
		chk({miso_oe, mosi_oe, sck_oe}, 12'h000);
		spsm_peer_inst.xfer(8'hFF, 1'b0, rx);
		tick(6);
		chk(flags.transfer_done_flag, 1'b0);
		fork
			spsm_peer_inst.xfer(8'h3C, 1'b1, rx);
			begin
				#300 chk(miso_oe, 1'b1);
			end
		join
		tick(6);
		chk(rx, 8'hA5);
		chk({rx_valid, flags.transfer_done_flag, rx_data}, {2'h3, 8'h3C});
		clr_all();
		// 3-wire master against a slave peer
		p_slave = 1'b1;
		spsm_peer_inst.load(8'h96);
		// Half period of four clocks leaves room for the two-flop MISO sync
		wr_ctl(8'h03, 2'h0, 1'b1, 1'b1);
		chk(sel_routed, 1'b0);
		chk({sck_oe, mosi_oe, miso_oe}, 12'h006);
		wr_dat(8'h5A);
		for (int i = 0; i < 400 && busy !== 1'b0; i++) tick(1);
		tick(6);
		chk(spsm_peer_inst.sr, 8'h5A);
		chk(spsm_peer_inst.rises, 8'h08);
		chk({flags.transfer_done_flag, rx_data}, {1'b1, 8'h96});
		clr_all();
		p_slave = 1'b0;
		// Select driven as an output at the lower mode bit
		for (int m = 2; m < 4; m++) begin
			wr_ctl(8'h01, m[1:0], 1'b1, 1'b1);
			chk({sel_routed, sel_n_oe, sel_n_out}, {9'h000, 2'h3, m[0]});
		end
		// 3-wire slave always drives, disabled port never does
		wr_ctl(8'h01, 2'h0, 1'b0, 1'b1);
		chk(miso_oe, 1'b1);
		wr_ctl(8'h01, 2'h0, 1'b0, 1'b0);
		chk(miso_oe, 1'b0);
		// Another master pulls select low
		wr_ctl(8'h01, 2'h1, 1'b1, 1'b1);
		chk(sck_oe, 1'b1);
		spsm_peer_inst.select(1'b1);
		tick(8);
		chk(ctl_rdata[1:0], 2'h0);
		chk({flags.mode_fault_flag, sck_oe}, 12'h002);
		spsm_peer_inst.select(1'b0);
		tick(4);
		tally_and_finish();
	end
endmodule
`default_nettype wire
